// *** src/psc_pkg.sv ***
// constants, opcodes and frame sizes for the privileged system control unit
package psc_pkg;

  // opcode words
  localparam logic [15:0] OP_RESET_EXT = 16'h4e70;
  localparam logic [15:0] OP_RTE       = 16'h4e73;
  localparam logic [15:0] OP_STOP      = 16'h4e72;

  // reset output pulse lengths, in core clock periods
  localparam int           RST_LEN_W   = 10;
  localparam logic [9:0]   RST_CYC_NEW = 10'h200;
  localparam logic [9:0]   RST_CYC_OLD = 10'h07c;

  // status word fields
  localparam int           SW_T1       = 15;
  localparam int           SW_T0       = 14;
  localparam int           SW_S        = 13;
  localparam int           SW_IPL_LO   = 8;
  localparam logic [1:0]   TRACE_ALL   = 2'b01;
  localparam logic [15:0]  SW_RST      = 16'h2700;

  // stack frame handling
  localparam logic [31:0]  SP_STEP_SW  = 32'h0000_0002;
  localparam logic [31:0]  SP_STEP_PC  = 32'h0000_0004;
  localparam int           FOW_FMT_LO  = 12;
  localparam logic [31:0]  SP_RST      = 32'h0000_0000;
  localparam logic [31:0]  PC_RST      = 32'h0000_0000;
  localparam logic [7:0]   FRAME_F0    = 8'h08;
  localparam logic [7:0]   FRAME_F1    = 8'h08;
  localparam logic [7:0]   FRAME_F2    = 8'h0c;
  localparam logic [7:0]   FRAME_F9    = 8'h14;
  localparam logic [31:0]  PC_STEP_EXT = 32'h0000_0002;

  // register port
  localparam int           REG_AW      = 4;
  localparam logic [3:0]   REG_EVENT   = 4'h0;
  localparam logic [3:0]   REG_MASK    = 4'h1;
  localparam logic [3:0]   REG_CTRL    = 4'h2;
  localparam logic [3:0]   REG_STATE   = 4'h3;
  localparam logic [3:0]   REG_PC      = 4'h4;
  localparam logic [3:0]   REG_SP      = 4'h5;
  localparam int           CTRL_LEGACY = 0;
  localparam logic         CTRL_RST    = 1'b0;

  // event bits
  localparam int           EV_W        = 6;
  localparam int           EV_PRIV     = 0;
  localparam int           EV_RSTDONE  = 1;
  localparam int           EV_RTE      = 2;
  localparam int           EV_HALT     = 3;
  localparam int           EV_WAKE     = 4;
  localparam int           EV_FMTERR   = 5;
  localparam logic [5:0]   MASK_RST    = 6'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RSTPULSE,
    ST_RD_SW,
    ST_RD_PC,
    ST_RD_FMT,
    ST_HALT
  } psc_state_e;

  // frame size for a format code; top bit flags a known format
  function automatic logic [8:0] psc_frame_bytes(input logic [3:0] fmt);
    case (fmt)
      4'h0:    return {1'b1, FRAME_F0};
      4'h1:    return {1'b1, FRAME_F1};
      4'h2:    return {1'b1, FRAME_F2};
      4'h9:    return {1'b1, FRAME_F9};
      default: return 9'h000;
    endcase
  endfunction

endpackage

// *** src/psc_pulse_timer.sv ***
// one-shot pulse of a loadable length, high for exactly len cycles
module psc_pulse_timer #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] len,
  output logic              active,
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         active;
    logic         done;
  } psc_tmr_s;

  psc_tmr_s s, n;

  always_comb begin
    n      = s;
    n.done = 1'b0;
    if (s.active) begin
      if (s.cnt == '0) begin
        n.active = 1'b0;
        n.done   = 1'b1;
      end else begin
        n.cnt = s.cnt - 1'b1;
      end
    end else if (start && len != '0) begin
      n.active = 1'b1;
      n.cnt    = len - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign active = s.active;
  assign done   = s.done;

endmodule

// *** src/psc_ctrl.sv ***
// execution unit for reset-external, return-from-exception and load-and-halt
module psc_ctrl (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      insn_valid,
  input  wire logic [15:0]               insn_word,
  input  wire logic [15:0]               insn_ext,
  input  wire logic [31:0]               insn_next_pc,
  input  wire logic                      sp_wr,
  input  wire logic [31:0]               sp_wr_data,
  input  wire logic                      mem_rd_ack,
  input  wire logic [31:0]               mem_rd_data,
  input  wire logic [2:0]                irq_level_pin,
  input  wire logic [psc_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [31:0]                    reg_rdata,
  output logic                           irq,
  output logic                           mem_rd_req,
  output logic [31:0]                    mem_rd_addr,
  output logic                           mem_rd_long,
  output logic                           busy,
  output logic                           insn_done,
  output logic                           priv_trap,
  output logic                           fmt_trap,
  output logic                           trace_exc,
  output logic                           irq_exc,
  output logic [2:0]                     irq_ack_level,
  output logic                           halted,
  output logic                           fetch_en,
  output logic                           reset_out_line,
  output logic [15:0]                    status_word,
  output logic [31:0]                    stack_pointer,
  output logic [31:0]                    pc_out
);
  import psc_pkg::*;

  typedef struct packed {
    psc_state_e         st;
    logic [15:0]        sw;
    logic [31:0]        sp;
    logic [31:0]        pc;
    logic [31:0]        base;
    logic               trace_pend;
    logic [RST_LEN_W-1:0] rst_len;
    logic [2:0]         irq_s1;
    logic [2:0]         irq_s2;
    logic [EV_W-1:0]    ev;
    logic [EV_W-1:0]    mask;
    logic               legacy;
    logic               irq;
    logic [31:0]        rdata;
    logic               rd_req;
    logic [31:0]        rd_addr;
    logic               rd_long;
    logic               busy;
    logic               done;
    logic               priv_trap;
    logic               fmt_trap;
    logic               trace_exc;
    logic               irq_exc;
    logic [2:0]         irq_ack;
    logic               halted;
    logic               fetch_en;
  } psc_ctrl_s;

  psc_ctrl_s s, n;
  logic [EV_W-1:0] ev_set;
  logic            tmr_start;
  logic            tmr_active;
  logic            tmr_done;
  logic            take;
  logic            known_op;
  logic [8:0]      frame;

  assign take     = (s.st == ST_IDLE) && insn_valid;
  assign known_op = (insn_word == OP_RESET_EXT) || (insn_word == OP_RTE) ||
                    (insn_word == OP_STOP);
  assign frame    = psc_frame_bytes(mem_rd_data[FOW_FMT_LO+3:FOW_FMT_LO]);

  psc_pulse_timer #(
    .W (RST_LEN_W)
  ) u_rst_timer (
    .clk    (core_clk),
    .rst    (rst),
    .start  (tmr_start),
    .len    (n.rst_len),
    .active (tmr_active),
    .done   (tmr_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n           = s;
    ev_set      = '0;
    tmr_start   = 1'b0;
    n.rdata     = '0;
    n.done      = 1'b0;
    n.priv_trap = 1'b0;
    n.fmt_trap  = 1'b0;
    n.trace_exc = 1'b0;
    n.irq_exc   = 1'b0;
    n.irq_s1    = irq_level_pin;
    n.irq_s2    = s.irq_s1;

    if (reg_wr) begin
      case (reg_addr)
        REG_MASK: n.mask   = reg_wdata[EV_W-1:0];
        REG_CTRL: n.legacy = reg_wdata[CTRL_LEGACY];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_EVENT: n.rdata = {26'h0, s.ev};
        REG_MASK:  n.rdata = {26'h0, s.mask};
        REG_CTRL:  n.rdata = {31'h0, s.legacy};
        REG_STATE: n.rdata = {14'h0, s.halted, s.busy, s.sw};
        REG_PC:    n.rdata = s.pc;
        REG_SP:    n.rdata = s.sp;
        default:   n.rdata = '0;
      endcase
    end
    // core-side stack pointer loads are only honoured between operations
    if (sp_wr && s.st == ST_IDLE) begin
      n.sp = sp_wr_data;
    end

    case (s.st)
      ST_IDLE: begin
        if (take && known_op) begin
          if (!s.sw[SW_S]) begin
            n.priv_trap     = 1'b1;
            ev_set[EV_PRIV] = 1'b1;
          end else if (insn_word == OP_RESET_EXT) begin
            n.rst_len = s.legacy ? RST_CYC_OLD : RST_CYC_NEW;
            tmr_start = 1'b1;
            n.pc      = insn_next_pc;
            n.st      = ST_RSTPULSE;
          end else if (insn_word == OP_RTE) begin
            n.base    = s.sp;
            n.rd_req  = 1'b1;
            n.rd_addr = s.sp;
            n.rd_long = 1'b0;
            n.st      = ST_RD_SW;
          end else begin
            n.trace_pend    = ({s.sw[SW_T1], s.sw[SW_T0]} == TRACE_ALL);
            n.sw            = insn_ext;
            n.pc            = insn_next_pc + PC_STEP_EXT;
            n.st            = ST_HALT;
            ev_set[EV_HALT] = 1'b1;
          end
        end
      end
      ST_RSTPULSE: begin
        if (tmr_done) begin
          n.done             = 1'b1;
          ev_set[EV_RSTDONE] = 1'b1;
          n.st               = ST_IDLE;
        end
      end
      ST_RD_SW: begin
        if (mem_rd_ack) begin
          n.sw      = mem_rd_data[15:0];
          n.sp      = s.sp + SP_STEP_SW;
          n.rd_addr = s.sp + SP_STEP_SW;
          n.rd_long = 1'b1;
          n.st      = ST_RD_PC;
        end
      end
      ST_RD_PC: begin
        if (mem_rd_ack) begin
          n.pc      = mem_rd_data;
          n.sp      = s.sp + SP_STEP_PC;
          n.rd_addr = s.sp + SP_STEP_PC;
          n.rd_long = 1'b0;
          n.st      = ST_RD_FMT;
        end
      end
      ST_RD_FMT: begin
        if (mem_rd_ack) begin
          n.rd_req  = 1'b0;
          n.rd_long = 1'b0;
          n.st      = ST_IDLE;
          // frame size from the type field
          if (frame[8]) begin
            n.sp           = s.base + {24'h0, frame[7:0]};
            n.done         = 1'b1;
            ev_set[EV_RTE] = 1'b1;
          end else begin
            // unknown frame type: stack left at the format word
            n.fmt_trap        = 1'b1;
            ev_set[EV_FMTERR] = 1'b1;
          end
        end
      end
      ST_HALT: begin
        // only trace or a high enough request wakes
        if (s.trace_pend) begin
          n.trace_exc     = 1'b1;
          n.trace_pend    = 1'b0;
          n.st            = ST_IDLE;
          ev_set[EV_WAKE] = 1'b1;
        end else if (s.irq_s2 > s.sw[SW_IPL_LO+2:SW_IPL_LO]) begin
          n.irq_exc       = 1'b1;
          n.irq_ack       = s.irq_s2;
          n.st            = ST_IDLE;
          ev_set[EV_WAKE] = 1'b1;
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // a read clears the events, but one arriving in the same cycle survives
    if (reg_rd && reg_addr == REG_EVENT) begin
      n.ev = ev_set;
    end else begin
      n.ev = s.ev | ev_set;
    end
    n.irq      = |(n.ev & n.mask);
    n.busy     = (n.st != ST_IDLE);
    n.halted   = (n.st == ST_HALT);
    n.fetch_en = (n.st != ST_HALT);
  end

  //////////////////////////////////////////////////////////////////////////////
  // external reset always restarts from the reset state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.sw       <= SW_RST;
      s.sp       <= SP_RST;
      s.pc       <= PC_RST;
      s.legacy   <= CTRL_RST;
      s.mask     <= MASK_RST;
      s.fetch_en <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata      = s.rdata;
  assign irq            = s.irq;
  assign mem_rd_req     = s.rd_req;
  assign mem_rd_addr    = s.rd_addr;
  assign mem_rd_long    = s.rd_long;
  assign busy           = s.busy;
  assign insn_done      = s.done;
  assign priv_trap      = s.priv_trap;
  assign fmt_trap       = s.fmt_trap;
  assign trace_exc      = s.trace_exc;
  assign irq_exc        = s.irq_exc;
  assign irq_ack_level  = s.irq_ack;
  assign halted         = s.halted;
  assign fetch_en       = s.fetch_en;
  assign reset_out_line = tmr_active;
  assign status_word    = s.sw;
  assign stack_pointer  = s.sp;
  assign pc_out         = s.pc;

  //////////////////////////////////////////////////////////////////////////////
  // checks; the high-time counter exists only for them
  logic [RST_LEN_W:0] hi_cnt;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_cnt <= '0;
    end else if (reset_out_line) begin
      hi_cnt <= hi_cnt + 1'b1;
    end else begin
      hi_cnt <= '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_sw_pop;
    s.st == ST_RD_SW && mem_rd_ack;
  endsequence
  sequence s_pc_pop;
    s.st == ST_RD_PC && mem_rd_ack;
  endsequence
  sequence s_fmt_pop;
    s.st == ST_RD_FMT && mem_rd_ack && frame[8];
  endsequence

  property p_user_trap;
    take && known_op && !status_word[SW_S] |=> priv_trap && !busy && !reset_out_line;
  endproperty
  a_user_trap: assert property (p_user_trap) else $error("user state op not trapped");

  property p_rst_len;
    $fell(reset_out_line) |-> hi_cnt == {1'b0, s.rst_len};
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse wrong length");

  property p_rst_keep;
    reset_out_line |-> $stable(status_word) && $stable(stack_pointer) && !halted;
  endproperty
  a_rst_keep: assert property (p_rst_keep) else $error("state moved during reset pulse");

  property p_rte_sp;
    s_pc_pop |=> stack_pointer == s.base + 32'h6;
  endproperty
  a_rte_sp: assert property (p_rte_sp) else $error("stack pops wrong");

  property p_rte_frame;
    s_fmt_pop |=> stack_pointer == $past(s.base) + {24'h0, $past(frame[7:0])} && !busy;
  endproperty
  a_rte_frame: assert property (p_rte_frame) else $error("frame not deallocated");

  property p_rte_flags;
    s_sw_pop |=> status_word == $past(mem_rd_data[15:0]) && mem_rd_long;
  endproperty
  a_rte_flags: assert property (p_rte_flags) else $error("flags not restored");

  property p_stop_load;
    take && status_word[SW_S] && insn_word == OP_STOP |=>
      halted && status_word == $past(insn_ext) && pc_out == $past(insn_next_pc) + 32'h2;
  endproperty
  a_stop_load: assert property (p_stop_load) else $error("halt load wrong");

  property p_wake;
    $fell(halted) && !$past(rst) |-> trace_exc || irq_exc;
  endproperty
  a_wake: assert property (p_wake) else $error("halt left without exception");

  property p_trace;
    take && status_word[SW_S] && insn_word == OP_STOP &&
      status_word[SW_T1:SW_T0] == TRACE_ALL |-> ##2 trace_exc;
  endproperty
  a_trace: assert property (p_trace) else $error("trace not taken");

  property p_irq_low;
    halted && !rst && !s.trace_pend && s.irq_s2 <= s.sw[10:8] |=> !irq_exc && halted;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low request woke core");

  property p_no_fetch;
    halted |-> !fetch_en && (!$past(halted) || $stable(pc_out));
  endproperty
  a_no_fetch: assert property (p_no_fetch) else $error("fetch while halted");

endmodule

// *** tb/psc_dev_model.sv ***
// far-side model: stack memory answering frame reads, and a device on the reset line
module psc_dev_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        mem_rd_req,
  input  wire logic [31:0] mem_rd_addr,
  input  wire logic        mem_rd_long,
  input  wire logic        reset_out_line,
  input  wire logic [1:0]  delay,
  output logic             mem_rd_ack,
  output logic [31:0]      mem_rd_data,
  output int               pulse_len
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] mem [0:255];
  logic [1:0] wait_q;
  int         run_q;
  logic [7:0] a;

  assign a = mem_rd_addr[7:0];

  initial begin
    mem_rd_data = 32'h5a5a_a5a5;
    mem_rd_ack  = 1'b0;
    wait_q      = 2'h0;
    run_q       = 0;
    pulse_len   = 0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // big-endian word and long reads
  // idle data toggles so a read taken at the wrong moment never looks right
  always @(posedge core_clk) begin
    if (rst || mem_rd_ack || !mem_rd_req) begin
      mem_rd_ack  <= 1'b0;
      wait_q      <= 2'h0;
      mem_rd_data <= ~mem_rd_data;
    end else if (wait_q != delay) begin
      wait_q      <= wait_q + 2'h1;
      mem_rd_data <= ~mem_rd_data;
    end else begin
      mem_rd_ack  <= 1'b1;
      mem_rd_data <= mem_rd_long ? {mem[a], mem[a+8'h1], mem[a+8'h2], mem[a+8'h3]}
                                 : {~mem_rd_data[31:16], mem[a], mem[a+8'h1]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // device measures pulse
  always @(posedge core_clk) begin
    if (reset_out_line) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      pulse_len <= run_q;
      run_q     <= 0;
    end
  end
endmodule

// *** tb/privileged_system_control_ops_bench.sv ***
// self-checking bench for the privileged system control unit
module privileged_system_control_ops_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import psc_pkg::*;

  logic        core_clk, rst, insn_valid, sp_wr, mem_rd_ack, reg_wr, reg_rd, irq;
  logic        mem_rd_req, mem_rd_long, busy, insn_done, priv_trap, fmt_trap;
  logic        trace_exc, irq_exc, halted, fetch_en, reset_out_line;
  logic [15:0] insn_word, insn_ext, status_word;
  logic [31:0] insn_next_pc, sp_wr_data, mem_rd_data, reg_wdata, reg_rdata;
  logic [31:0] mem_rd_addr, stack_pointer, pc_out;
  logic [2:0]  irq_level_pin, irq_ack_level;
  logic [3:0]  reg_addr, evs;
  logic [1:0]  delay;
  logic [15:0] ops [3] = '{OP_RESET_EXT, OP_RTE, OP_STOP};
  int          n_fail, n_tests, cyc, pulse_len;

  psc_ctrl uut (
    .core_clk, .rst, .insn_valid, .insn_word, .insn_ext, .insn_next_pc, .sp_wr,
    .sp_wr_data, .mem_rd_ack, .mem_rd_data, .irq_level_pin, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .irq, .mem_rd_req, .mem_rd_addr, .mem_rd_long, .busy,
    .insn_done, .priv_trap, .fmt_trap, .trace_exc, .irq_exc, .irq_ack_level, .halted,
    .fetch_en, .reset_out_line, .status_word, .stack_pointer, .pc_out
  );

  psc_dev_model dev (
    .core_clk, .rst, .mem_rd_req, .mem_rd_addr, .mem_rd_long, .reset_out_line, .delay,
    .mem_rd_ack, .mem_rd_data, .pulse_len
  );

  assign evs = {irq_exc, trace_exc, fmt_trap, insn_done};

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
    tick(1);
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
    tick(1);
  endtask

  task automatic issue(input logic [15:0] w, input logic [15:0] x, input logic [31:0] pc);
    insn_word    <= w;
    insn_ext     <= x;
    insn_next_pc <= pc;
    insn_valid   <= 1'b1;
    tick(1);
    insn_valid <= 1'b0;
    #1;
  endtask

  // sel: 0 done, 1 format error, 2 trace, 3 interrupt
  task automatic wait_ev(input int sel);
    int n;
    n = 0;
    while (evs[sel] !== 1'b1 && n < 600) begin
      tick(1);
      #1;
      n++;
    end
    chk(n < 600, 1'b1);
  endtask

  task automatic return_from_exception_op(input logic [7:0] b, input logic [15:0] sr, input logic [31:0] pc,
                     input logic [15:0] fw);
    {dev.mem[b], dev.mem[b+8'h1]} = sr;
    {dev.mem[b+8'h2], dev.mem[b+8'h3], dev.mem[b+8'h4], dev.mem[b+8'h5]} = pc;
    {dev.mem[b+8'h6], dev.mem[b+8'h7]} = fw;
    sp_wr_data <= {24'h0, b};
    sp_wr      <= 1'b1;
    tick(1);
    sp_wr <= 1'b0;
    tick(1);
    issue(OP_RTE, 16'h0, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always #5 core_clk = ~core_clk;

  // whole run is near 750 cycles, so this only trips on a hang
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    {core_clk, rst, insn_valid, sp_wr, reg_wr, reg_rd, irq_level_pin, delay} = 11'h200;
    {insn_word, insn_ext, insn_next_pc, sp_wr_data, reg_wdata, reg_addr} = '0;
    {n_fail, n_tests, cyc} = '0;
    tick(12);
    rst <= 1'b0;
    tick(1);
    rd(REG_STATE, 32'h0000_2700);
    rd(4'hf, 32'h0);
    wr(REG_MASK, 32'h3f);
    issue(OP_RESET_EXT, 16'h0, 32'h40);
    chk(reset_out_line, 1'b1);
    chk(pc_out, 32'h40);
    issue(OP_STOP, 16'h2000, 32'h80);
    wait_ev(0);
    tick(1);
    #1 chk(pulse_len, 512);
    chk({halted, status_word}, 17'h0_2700);
    chk(irq, 1'b1);
    rd(REG_EVENT, 32'h2);
    wr(REG_CTRL, 32'h1);
    issue(OP_RESET_EXT, 16'h0, 32'h44);
    wait_ev(0);
    tick(1);
    #1 chk(pulse_len, 124);
    wr(REG_CTRL, 32'h0);
    wr(REG_MASK, 32'h20);
    rd(REG_EVENT, 32'h2);
    chk(irq, 1'b0);
    delay <= 2'h2;
    return_from_exception_op(8'h10, 16'h6715, 32'h300, 16'h2008);
    wait_ev(0);
    chk(status_word, 16'h6715);
    chk(status_word[4:0], 5'h15);
    chk(pc_out, 32'h300);
    chk(stack_pointer, 32'h1c);
    issue(OP_STOP, 16'h2000, 32'h400);
    chk({halted, fetch_en}, 2'b10);
    chk(status_word, 16'h2000);
    chk(pc_out, 32'h402);
    wait_ev(2);
    tick(1);
    #1 chk(halted, 1'b0);
    issue(OP_STOP, 16'h2315, 32'h500);
    irq_level_pin <= 3'h3;
    tick(8);
    #1 chk(halted, 1'b1);
    irq_level_pin <= 3'h4;
    wait_ev(3);
    chk(irq_ack_level, 3'h4);
    irq_level_pin <= 3'h0;
    tick(1);
    #1 chk({halted, irq}, 2'b00);
    delay <= 2'h0;
    return_from_exception_op(8'h40, 16'h2700, 32'h600, 16'hf000);
    wait_ev(1);
    chk(stack_pointer, 32'h46);
    chk(irq, 1'b1);
    rd(REG_EVENT, 32'h3c);
    issue(OP_STOP, 16'h2700, 32'h700);
    chk(halted, 1'b1);
    rst <= 1'b1;
    tick(1);
    rst <= 1'b0;
    #1 chk({halted, status_word}, 17'h0_2700);
    tick(1);
    return_from_exception_op(8'h80, 16'h001f, 32'h800, 16'h0000);
    wait_ev(0);
    chk(status_word, 16'h001f);
    chk(stack_pointer, 32'h88);
    foreach (ops[i]) begin
      issue(ops[i], 16'h2700, 32'h900);
      chk(priv_trap, 1'b1);
      chk({busy, halted, reset_out_line}, 3'h0);
      tick(1);
    end
    rd(REG_STATE, 32'h0000_001f);
    give_verdict();
  end
endmodule
